// [verilog/cplm_cfg.svh]
// Named offsets, field positions, reset values and bus codes for the level mask.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef CPLM_CFG_SVH
`define CPLM_CFG_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define CPLM_OFS_STATUS 8'h00
`define CPLM_OFS_CORE   8'h04
`define CPLM_OFS_TRAP   8'h08

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CPLM_LOW_MSB  7
`define CPLM_LOW_LSB  5
`define CPLM_TOP_BIT  3
`define CPLM_NEST_BIT 15

// ------------------------------------------------------------
// Reset values and special codes
// ------------------------------------------------------------
`define CPLM_LOW_RST     3'h0
`define CPLM_TOP_RST     1'h0
`define CPLM_NEST_RST    1'h0
`define CPLM_LOW_MASKALL 3'h7
`define CPLM_WORD_ZERO   32'h0000_0000
`define CPLM_RESP_OKAY   2'h0
`define CPLM_RESP_DECERR 2'h3

`endif

// [verilog/cplm_pkg.sv]
// Types shared by the priority level mask modules.
// Assumes the constants header sits beside it.
`include "cplm_cfg.svh"

package cplm_pkg;
  typedef logic [2:0]  cplm_low_t;   // Lower three level bits
  typedef logic [3:0]  cplm_level_t; // Full four-bit level
  typedef logic [1:0]  cplm_resp_t;  // Bus response code
  typedef logic [31:0] cplm_word_t;  // Bus data word
endpackage

// [verilog/cplm_level_reg.sv]
// Holds the current priority level: low field and top bit.
// Assumes same-clock hardware strobes; top bit changes only by hardware.
`timescale 1ns/1ps
`include "cplm_cfg.svh"

module cplm_level_reg (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  sw_low_we,
  input  wire cplm_pkg::cplm_low_t   sw_low_val,
  input  wire logic                  nesting_disable,
  input  wire logic                  trap_enter,
  input  wire logic                  trap_exit,
  input  wire logic                  hw_load,
  input  wire cplm_pkg::cplm_level_t hw_level,
  output logic                       top_q,
  output cplm_pkg::cplm_low_t        low_q
);
  import cplm_pkg::*;

  cplm_low_t low_d; // Next low field
  logic      top_d; // Next top bit

  // ------------------------------------------------------------
  // Next level
  // ------------------------------------------------------------
  // Hardware loads win over software; trap entry wins over all
  always_comb begin
    low_d = low_q;
    top_d = top_q;
    if (sw_low_we && !nesting_disable) begin
      low_d = sw_low_val;
    end
    if (hw_load) begin
      low_d = hw_level[2:0];
      top_d = hw_level[3];
    end
    if (trap_exit) begin
      top_d = 1'b0;
    end
    if (trap_enter) begin // Software has no path here
      top_d = 1'b1;
    end
  end

  // Register only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_q <= `CPLM_LOW_RST;
      top_q <= `CPLM_TOP_RST;
    end else begin
      low_q <= low_d;
      top_q <= top_d;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sw_write_a: assert property (
    sw_low_we && !nesting_disable && !hw_load |=> low_q == $past(sw_low_val))
    else $error("low field not written");
  nest_lock_a: assert property (
    sw_low_we && nesting_disable && !hw_load |=> $stable(low_q))
    else $error("low field written while locked");
  top_guard_a: assert property (
    $rose(top_q) |-> $past(trap_enter) || ($past(hw_load) && $past(hw_level[3])))
    else $error("top bit set without hardware cause");
endmodule

// [verilog/cplm_accept.sv]
// Decides whether a pending, enabled user interrupt may be taken.
// Assumes level and request inputs come from logic on the same clock.
`timescale 1ns/1ps
`include "cplm_cfg.svh"

module cplm_accept (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire cplm_pkg::cplm_level_t level,
  input  wire logic                  irq_pending,
  input  wire logic                  irq_enabled,
  input  wire cplm_pkg::cplm_low_t   irq_priority,
  output logic                       accept_q
);
  import cplm_pkg::*;

  logic accept_d; // Next accept decision

  // ------------------------------------------------------------
  // Decision
  // ------------------------------------------------------------
  // Explicit masks kept although the compare covers them
  always_comb begin
    accept_d = irq_pending && irq_enabled
      && !level[3]
      && (level[2:0] != `CPLM_LOW_MASKALL)
      && ({1'b0, irq_priority} > level);
  end

  // Register only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      accept_q <= 1'b0;
    end else begin
      accept_q <= accept_d;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  top_mask_a: assert property (level[3] |=> !accept_q)
    else $error("accepted with top bit set");
  full_mask_a: assert property (
    level[2:0] == `CPLM_LOW_MASKALL |=> !accept_q)
    else $error("accepted at level seven");
  above_take_a: assert property (
    irq_pending && irq_enabled && ({1'b0, irq_priority} > level) |=> accept_q)
    else $error("higher priority not accepted");
  below_drop_a: assert property (
    ({1'b0, irq_priority} <= level) |=> !accept_q)
    else $error("lower priority accepted");
endmodule

// [verilog/cplm_top.sv]
// AXI4-Lite slave holding the CPU priority level and its mask decision.
// Assumes one clock, synchronous active-low reset, hardware strobes on aclk.
`timescale 1ns/1ps
`include "cplm_cfg.svh"

// Overview of operation
// - Status bits 7:5 hold writable level field
// - Core control bit 3 tops four-bit level
// - Software can never set the top bit
// - Field 0..7 gives level 0..7 or 8..15
// - Field 111 blocks all user interrupts
// - Top bit set blocks all user interrupts
// - Nesting disable makes field read-only
// - Sources carry one of eight priorities
module cplm_top #(
  parameter int ADDR_W = 8 // Byte address width
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // Write address channel
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  // Write data channel
  input  wire cplm_pkg::cplm_word_t  s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // Write response channel
  output cplm_pkg::cplm_resp_t       s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // Read address channel
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  // Read data channel
  output cplm_pkg::cplm_word_t       s_axi_rdata,
  output cplm_pkg::cplm_resp_t       s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Hardware level control
  input  wire logic                  trap_enter,
  input  wire logic                  trap_exit,
  input  wire logic                  hw_load,
  input  wire cplm_pkg::cplm_level_t hw_level,
  // User interrupt request
  input  wire logic                  irq_pending,
  input  wire logic                  irq_enabled,
  input  wire cplm_pkg::cplm_low_t   irq_priority,
  output logic                       irq_accept,
  output cplm_pkg::cplm_level_t      cpu_level
);
  import cplm_pkg::*;

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic              aw_hold_q, aw_hold_d;   // Address waiting
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;     // Held write address
  logic              w_hold_q, w_hold_d;     // Data waiting
  cplm_word_t        wdata_q, wdata_d;       // Held write data
  logic [3:0]        wstrb_q, wstrb_d;       // Held byte enables
  logic              awready_q, awready_d;   // Address ready
  logic              wready_q, wready_d;     // Data ready
  logic              bvalid_q, bvalid_d;     // Response valid
  cplm_resp_t        bresp_q, bresp_d;       // Response code
  logic              arready_q, arready_d;   // Read address ready
  logic              rvalid_q, rvalid_d;     // Read data valid
  cplm_word_t        rdata_q, rdata_d;       // Read data
  cplm_resp_t        rresp_q, rresp_d;       // Read response
  logic              nest_q, nest_d;         // Nesting disable bit
  cplm_level_t       level_q, level_d;       // Level copy for output
  logic              wr_fire;                // Write commits now
  logic              sel_status, sel_core, sel_trap; // Write decode
  logic              sw_low_we;              // Field write strobe
  logic              top_q;                  // Top bit from holder
  cplm_low_t         low_q;                  // Low field from holder
  logic              accept_q;               // Accept from decider

  // ------------------------------------------------------------
  // Write channels
  // ------------------------------------------------------------
  // Address and data taken in either order; commit once both held
  // and no response is still waiting, so one write at a time
  always_comb begin
    aw_hold_d = aw_hold_q;
    awaddr_d  = awaddr_q;
    w_hold_d  = w_hold_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    wr_fire   = aw_hold_q && w_hold_q && !bvalid_q;
    if (s_axi_awvalid && awready_q) begin // Address handshake
      aw_hold_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin // Data handshake
      w_hold_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb_d  = s_axi_wstrb;
    end
    if (bvalid_q && s_axi_bready) begin // Response taken
      bvalid_d = 1'b0;
    end
    if (wr_fire) begin // Commit and answer
      aw_hold_d = 1'b0;
      w_hold_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = (sel_status || sel_core || sel_trap) ?
                  `CPLM_RESP_OKAY : `CPLM_RESP_DECERR;
    end
    awready_d = !aw_hold_d;
    wready_d  = !w_hold_d;
  end

  // Write decode on the held address
  always_comb begin
    sel_status = (awaddr_q == ADDR_W'(`CPLM_OFS_STATUS));
    sel_core   = (awaddr_q == ADDR_W'(`CPLM_OFS_CORE));
    sel_trap   = (awaddr_q == ADDR_W'(`CPLM_OFS_TRAP));
    sw_low_we  = wr_fire && sel_status && wstrb_q[0];
  end

  // Register only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      awaddr_q  <= '0;
      w_hold_q  <= 1'b0;
      wdata_q   <= `CPLM_WORD_ZERO;
      wstrb_q   <= 4'h0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `CPLM_RESP_OKAY;
    end else begin
      aw_hold_q <= aw_hold_d;
      awaddr_q  <= awaddr_d;
      w_hold_q  <= w_hold_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
    end
  end

  // ------------------------------------------------------------
  // Trap control word
  // ------------------------------------------------------------
  // Only the nesting disable bit lives here; trap flags are elsewhere
  always_comb begin
    nest_d = nest_q;
    if (wr_fire && sel_trap && wstrb_q[1]) begin
      nest_d = wdata_q[`CPLM_NEST_BIT];
    end
  end

  // Register only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nest_q <= `CPLM_NEST_RST;
    end else begin
      nest_q <= nest_d;
    end
  end

  // ------------------------------------------------------------
  // Level holder and accept decision
  // ------------------------------------------------------------
  cplm_level_reg cplm_level_reg_inst (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .sw_low_we       (sw_low_we),
    .sw_low_val      (wdata_q[`CPLM_LOW_MSB:`CPLM_LOW_LSB]),
    .nesting_disable (nest_q),
    .trap_enter      (trap_enter),
    .trap_exit       (trap_exit),
    .hw_load         (hw_load),
    .hw_level        (hw_level),
    .top_q           (top_q),
    .low_q           (low_q)
  );

  cplm_accept cplm_accept_inst (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .level        ({top_q, low_q}),
    .irq_pending  (irq_pending),
    .irq_enabled  (irq_enabled),
    .irq_priority (irq_priority),
    .accept_q     (accept_q)
  );

  // Output copy of the joined level, one cycle behind the holder
  always_comb begin
    level_d = {top_q, low_q};
  end

  // Register only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_q <= {`CPLM_TOP_RST, `CPLM_LOW_RST};
    end else begin
      level_q <= level_d;
    end
  end

  // ------------------------------------------------------------
  // Read channels
  // ------------------------------------------------------------
  // Answer one cycle after the address; unused bits read zero
  always_comb begin
    arready_d = arready_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (rvalid_q && s_axi_rready) begin // Data taken
      rvalid_d  = 1'b0;
      arready_d = 1'b1;
    end
    if (!rvalid_q && !arready_q) begin // Leave reset
      arready_d = 1'b1;
    end
    if (s_axi_arvalid && arready_q) begin // Address handshake
      arready_d = 1'b0;
      rvalid_d  = 1'b1;
      rdata_d   = `CPLM_WORD_ZERO;
      rresp_d   = `CPLM_RESP_OKAY;
      if (s_axi_araddr == ADDR_W'(`CPLM_OFS_STATUS)) begin
        rdata_d[`CPLM_LOW_MSB:`CPLM_LOW_LSB] = low_q;
      end else if (s_axi_araddr == ADDR_W'(`CPLM_OFS_CORE)) begin
        rdata_d[`CPLM_TOP_BIT] = top_q;
      end else if (s_axi_araddr == ADDR_W'(`CPLM_OFS_TRAP)) begin
        rdata_d[`CPLM_NEST_BIT] = nest_q;
      end else begin
        rresp_d = `CPLM_RESP_DECERR;
      end
    end
  end

  // Register only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= `CPLM_WORD_ZERO;
      rresp_q   <= `CPLM_RESP_OKAY;
    end else begin
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign irq_accept    = accept_q;
  assign cpu_level     = level_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // A status write with the lock clear, then the written field on the level output
  sequence status_write_s;
    wr_fire && sel_status && wstrb_q[0] && !nest_q && !hw_load;
  endsequence

  sequence field_seen_s;
    level_q[2:0] == $past(wdata_q[`CPLM_LOW_MSB:`CPLM_LOW_LSB], 2);
  endsequence

  level_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
    status_write_s ##1 !hw_load |=> field_seen_s)
    else $error("written field not on level output");
  level_join_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 cpu_level == {$past(top_q), $past(low_q)})
    else $error("level output not joined from fields");
  core_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && arready_q && s_axi_araddr == ADDR_W'(`CPLM_OFS_CORE)
    |=> s_axi_rvalid && s_axi_rdata[`CPLM_TOP_BIT] == $past(top_q))
    else $error("top bit read back wrong");
  no_sw_top_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && sel_core && !trap_enter && !hw_load && !top_q |=> !top_q)
    else $error("software write raised top bit");
  lock_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sw_low_we && nest_q && !hw_load |=> ##1 level_q[2:0] == $past(level_q[2:0]))
    else $error("locked field changed by write");
  wr_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire |=> s_axi_bvalid)
    else $error("write not answered next cycle");
  rd_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  mask_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
    top_q |=> !irq_accept)
    else $error("accept with top bit set");
endmodule

// [tb/cplm_top_tb.sv]
// Self-checking bench for the priority level mask: AXI4-Lite, trap strobes, accept.
// Assumes the design package and constants header are compiled first.
`timescale 1ns/1ps
`include "cplm_cfg.svh"

module cplm_top_tb;
  import cplm_pkg::*;
  // ------------------------------------------------------------
  // Compare macro: counts every compare, reports mismatches
  // ------------------------------------------------------------
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin num_errors++; \
  $display("wrong value at %0t: got %h exp %h", $time, (got), (exp)); end end

  logic        aclk, aresetn;                       // Clock and reset
  logic [7:0]  awaddr, araddr;                      // Bus addresses
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  cplm_word_t  wdata, rdata;                        // Bus data
  logic [3:0]  wstrb;                               // Byte lanes
  cplm_resp_t  bresp, rresp;                        // Responses
  logic        trap_enter, trap_exit, hw_load;      // Hardware strobes
  cplm_level_t hw_level, cpu_level;                 // Loaded and shown level
  logic        irq_pending, irq_enabled, irq_accept;
  cplm_low_t   irq_priority;                        // Source priority
  int          num_errors, n_tests, cycles;         // Counters
  logic [33:0] exp_r[$], er;                        // Read notes {rdata,rresp}
  cplm_resp_t  exp_b[$], eb;                        // Write response notes
  logic [31:0] lfsr_state;                          // Random source
  cplm_low_t   m_low;                               // Model of low field
  logic        m_top, m_nest;                       // Model of top and lock bits
  cplm_level_t exp_l[$], el;                        // Level notes
  logic        exp_a[$], ea;                        // Accept notes
  logic        look_l, look_a;                      // Marks a cycle a note applies to

  cplm_top cplm_top_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .trap_enter(trap_enter), .trap_exit(trap_exit), .hw_load(hw_load), .hw_level(hw_level),
    .irq_pending(irq_pending), .irq_enabled(irq_enabled), .irq_priority(irq_priority),
    .irq_accept(irq_accept), .cpu_level(cpu_level)
  );

  // ------------------------------------------------------------
  // Clock, timeout and response monitor
  // ------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // Ceiling well above the roughly 600 cycles the sequence needs
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  // Oldest note is compared whenever a result appears
  always @(posedge aclk) begin
    if (rvalid && rready) begin
      er = exp_r.pop_front();
      `CHK({rdata, rresp}, er)
    end
    if (bvalid && bready) begin
      eb = exp_b.pop_front();
      `CHK(bresp, eb)
    end
    if (look_l) begin
      el = exp_l.pop_front();
      `CHK(cpu_level, el)
    end
    if (look_a) begin
      ea = exp_a.pop_front();
      `CHK(irq_accept, ea)
    end
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    lfsr_state = {lfsr_state[30:0], lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1] ^
                  lfsr_state[0]};
    return lfsr_state;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == `CPLM_OFS_STATUS || a == `CPLM_OFS_CORE || a == `CPLM_OFS_TRAP;
  endfunction

  // Write: both channels offered together, each released when taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    exp_b.push_back(mapped(a) ? `CPLM_RESP_OKAY : `CPLM_RESP_DECERR);
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= s; wvalid <= 1'b1; bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awvalid && awready && !aw_done) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready && !w_done) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    // Model: lock ignores the field, top bit never software-writable
    if (a == `CPLM_OFS_STATUS && s[0] && !m_nest) m_low = d[7:5];
    if (a == `CPLM_OFS_TRAP && s[1]) m_nest = d[15];
  endtask

  task automatic axi_read(input logic [7:0] a);
    logic [31:0] ev;
    ev = 32'h0000_0000;
    if (a == `CPLM_OFS_STATUS) ev[7:5] = m_low;
    if (a == `CPLM_OFS_CORE) ev[3] = m_top;
    if (a == `CPLM_OFS_TRAP) ev[15] = m_nest;
    exp_r.push_back({ev, mapped(a) ? `CPLM_RESP_OKAY : `CPLM_RESP_DECERR});
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
  endtask

  // Level output lags a commit by two edges; four leaves margin
  task automatic chk_lvl();
    repeat (3) @(posedge aclk);
    exp_l.push_back({m_top, m_low});
    look_l <= 1'b1;
    @(posedge aclk);
    look_l <= 1'b0;
  endtask

  task automatic chk_irq(input logic p, input logic e, input cplm_low_t pr);
    logic ex;
    ex = p & e & !m_top & (m_low != `CPLM_LOW_MASKALL) & ({1'b0, pr} > {m_top, m_low});
    @(posedge aclk);
    irq_pending <= p; irq_enabled <= e; irq_priority <= pr;
    repeat (2) @(posedge aclk);
    exp_a.push_back(ex);
    look_a <= 1'b1;
    @(posedge aclk);
    look_a <= 1'b0;
  endtask

  task automatic pulse(input int which, input cplm_level_t v);
    @(posedge aclk);
    if (which == 0) trap_enter <= 1'b1;
    if (which == 1) trap_exit <= 1'b1;
    if (which == 2) begin
      hw_load <= 1'b1;
      hw_level <= v;
    end
    @(posedge aclk);
    trap_enter <= 1'b0; trap_exit <= 1'b0; hw_load <= 1'b0;
    if (which == 0) m_top = 1'b1;
    if (which == 1) m_top = 1'b0;
    if (which == 2) {m_top, m_low} = v;
  endtask

  task automatic wrap_up();
    $display("errors %0d compares %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    aresetn = 1'b0; awaddr = 8'h00; araddr = 8'h00; awvalid = 1'b0; wvalid = 1'b0;
    bready = 1'b0; arvalid = 1'b0; rready = 1'b0; wdata = 32'h0000_0000; wstrb = 4'h0;
    trap_enter = 1'b0; trap_exit = 1'b0; hw_load = 1'b0; hw_level = 4'h0;
    irq_pending = 1'b0; irq_enabled = 1'b0; irq_priority = 3'h0;
    num_errors = 0; n_tests = 0; cycles = 0; lfsr_state = 32'h5181_4b1a;
    look_l = 1'b0; look_a = 1'b0;
    m_low = 3'h0; m_top = 1'b0; m_nest = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    // Reset values of all three words, plus an unmapped place
    axi_read(`CPLM_OFS_STATUS);
    axi_read(`CPLM_OFS_CORE);
    axi_read(`CPLM_OFS_TRAP);
    axi_read(8'h0c);
    axi_write(8'h10, rnd(), 4'hf);
    chk_lvl();
    // Every field value against every source priority
    for (int v = 0; v < 8; v++) begin
      axi_write(`CPLM_OFS_STATUS, (rnd() & 32'hffff_ff1f) | (v << 5), 4'hf);
      axi_read(`CPLM_OFS_STATUS);
      chk_lvl();
      for (int p = 0; p < 8; p++) chk_irq(1'b1, 1'b1, 3'(p));
    end
    // Without pending or enable nothing is taken
    axi_write(`CPLM_OFS_STATUS, 32'h0000_0000, 4'h1);
    chk_irq(1'b0, 1'b1, 3'h7);
    chk_irq(1'b1, 1'b0, 3'h7);
    // Field lane not strobed: no change
    axi_write(`CPLM_OFS_STATUS, 32'h0000_00a0, 4'he);
    axi_read(`CPLM_OFS_STATUS);
    // Software cannot raise the top bit
    axi_write(`CPLM_OFS_CORE, 32'hffff_ffff, 4'hf);
    axi_read(`CPLM_OFS_CORE);
    chk_lvl();
    // Trap entry raises level into 8..15 and masks everything
    axi_write(`CPLM_OFS_STATUS, 32'h0000_0040, 4'h1);
    pulse(0, 4'h0);
    chk_lvl();
    axi_read(`CPLM_OFS_CORE);
    for (int p = 0; p < 8; p++) chk_irq(1'b1, 1'b1, 3'(p));
    axi_write(`CPLM_OFS_CORE, 32'h0000_0000, 4'hf);
    axi_read(`CPLM_OFS_CORE);
    pulse(1, 4'h0);
    chk_lvl();
    chk_irq(1'b1, 1'b1, 3'h3);
    // Nesting lock: field read-only, response still okay
    axi_write(`CPLM_OFS_TRAP, 32'h0000_8000, 4'h2);
    axi_read(`CPLM_OFS_TRAP);
    axi_write(`CPLM_OFS_STATUS, 32'h0000_00e0, 4'hf);
    axi_read(`CPLM_OFS_STATUS);
    chk_lvl();
    // Hardware load still moves the level under the lock
    for (int i = 0; i < 4; i++) begin
      pulse(2, 4'(rnd()));
      chk_lvl();
      chk_irq(1'b1, 1'b1, 3'(rnd()));
    end
    pulse(1, 4'h0);
    axi_write(`CPLM_OFS_TRAP, 32'h0000_0000, 4'h2);
    axi_write(`CPLM_OFS_STATUS, 32'h0000_0020, 4'h1);
    axi_read(`CPLM_OFS_STATUS);
    chk_lvl();
    repeat (4) @(posedge aclk);
    wrap_up();
  end
endmodule
